// ===== test/tpa_pin_src.sv
// Model of the external signal source on the four channel pins
`timescale 1ns/1ns
`default_nettype none
module tpa_pin_src (
    input wire logic clk,
    output logic [3:0] pin
);
    // Pins idle low
    initial pin = 4'h0;
    // Levels held whole clocks, well over two
    task automatic drive(input int ch, input logic lvl, input int cycles);
        pin[ch] <= lvl;
        repeat (cycles) @(posedge clk);
    endtask : drive
endmodule : tpa_pin_src
`default_nettype wire

// ===== test/tpa_timer_core_bench.sv
// Self-checking bench for the timer capture/compare block
`timescale 1ns/1ns
`default_nettype none
module tpa_timer_core_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq_ain, irq_aovf, irq_tof;
    logic [31:0] hrdata, q;
    logic [3:0] pin_i, pin_o, pin_oe, irq_chan;
    logic [15:0] ev;
    int fail_count = 0;
    int checks_done = 0;
    // Rows: address, write value, read-back value (reserved bits drop)
    localparam logic [71:0] ROWS [12] = '{{8'h00, 32'h7F, 32'h37}, {8'h04, 32'hFF, 32'h0F},
        {8'h08, 32'hFF, 32'hFF}, {8'h0C, 32'hFF, 32'h0F}, {8'h14, 32'hFF, 32'h00},
        {8'h18, 32'hFF, 32'hFF}, {8'h20, 32'hFFFF_FFFF, 32'hFFFF}, {8'h2C, 32'h5678, 32'h5678},
        {8'h38, 32'hFFFF_1234, 32'h1234}, {8'h3C, 32'hFF, 32'hFF}, {8'h30, 32'hFF, 32'h73},
        {8'h40, 32'hFF, 32'h00}};
    // Forced codes: mode/level value and pin
    localparam logic [15:0] FC [3] = '{16'h1000, 16'h0100, 16'h1101};
    tpa_timer_core uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_pin_i(pin_i),
        .chan_pin_o(pin_o), .chan_pin_oe(pin_oe), .irq_chan(irq_chan), .irq_accum_input(irq_ain),
        .irq_accum_overflow(irq_aovf), .irq_counter_overflow(irq_tof));
    tpa_pin_src src (.clk(clk), .pin(pin_i));
    initial forever #20 clk = ~clk;
    task automatic test_done();
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        fail_count += (got !== exp);
        if (got !== exp) $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    endtask : cmp
    // Address phase, then data phase; each held until ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        int n = 0;
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
        if (n >= 100) begin fail_count++; test_done(); end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        cmp(q, e);
    endtask : chk
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset value, write, read back, restore
        foreach (ROWS[i])
        begin
            chk(ROWS[i][71:64], 32'h0);
            wr(ROWS[i][71:64], ROWS[i][63:32]);
            chk(ROWS[i][71:64], ROWS[i][31:0]);
            wr(ROWS[i][71:64], 32'h0);
        end
        // Stopped timer: capture copies idle count
        wr(8'h20, 32'hAAAA);
        wr(8'h0C, 32'h1);
        src.drive(0, 1'b1, 8);
        src.drive(0, 1'b0, 8);
        chk(8'h20, 32'h0);
        chk(8'h10, 32'h1);
        cmp({28'h0, irq_chan}, 32'h1);
        wr(8'h10, 32'h1F);
        // Match at 5 sets the pin, then forced actions walk the toggle, clear and set codes
        wr(8'h20, 32'h5);
        wr(8'h08, 32'h11);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h80);
        for (int n = 0; n < 200 && pin_o[0] !== 1'b1; n++) @(posedge clk);
        cmp({30'h0, pin_oe[0], pin_o[0]}, 32'h3);
        chk(8'h10, 32'h1);
        wr(8'h10, 32'h1F);
        foreach (FC[i])
        begin
            wr(8'h08, {24'h0, FC[i][15:8]});
            wr(8'h14, 32'h1);
            @(negedge clk);
            cmp({31'h0, pin_o[0]}, {31'h0, FC[i][0]});
        end
        chk(8'h10, 32'h0);
        // Port latch stays hidden while compare owns the pin
        wr(8'h3C, 32'h10);
        @(negedge clk);
        cmp({30'h0, pin_oe[0], pin_o[0]}, 32'h3);
        wr(8'h08, 32'h0);
        @(negedge clk);
        cmp({30'h0, pin_oe[0], pin_o[0]}, 32'h2);
        wr(8'h3C, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        // Edge counting, timer stopped, pin left detached from compare
        ev = 16'hFFFF;
        wr(8'h38, {16'h0, ev});
        for (int s = 1; s >= 0; s--)
        begin
            wr(8'h30, {25'h0, 1'b1, 1'b0, s[0], 4'h2});
            for (int h = 1; h >= 0; h--)
            begin
                src.drive(3, h[0], 8);
                if (h == s) ev++;
                chk(8'h38, {16'h0, ev});
            end
        end
        chk(8'h34, 32'h3);
        cmp({31'h0, irq_aovf}, 32'h1);
        wr(8'h34, 32'h2);
        chk(8'h34, 32'h1);
        wr(8'h34, 32'h1);
        chk(8'h34, 32'h0);
        // Gated: no ticks while stopped, else one per 64 clocks
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h00, {24'h0, k > 0, 7'h0});
            wr(8'h30, {27'h3, k == 2, 4'h1});
            src.drive(3, k == 2, 8);
            wr(8'h38, 32'h0);
            wr(8'h34, 32'h3);
            src.drive(3, k != 2, 640);
            src.drive(3, k == 2, 8);
            bus(1'b0, 8'h38, 32'h0, q);
            cmp({31'h0, (k == 0) ? q == 0 : (q >= 9 && q <= 11)}, 32'h1);
            chk(8'h34, 32'h1);
            cmp({31'h0, irq_ain}, 32'h1);
        end
        test_done();
    end
endmodule : tpa_timer_core_bench
`default_nettype wire

// ===== test/tpa_timer_monitor.sv
// Port-level checker for the timer capture/compare block
`timescale 1ns/1ns
`default_nettype none
module tpa_timer_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0] chan_pin_i,
    input wire logic [3:0] chan_pin_oe,
    input wire logic [3:0] irq_chan,
    input wire logic irq_accum_input,
    input wire logic irq_accum_overflow,
    input wire logic irq_counter_overflow
);
    // ------------------------------------------------------------
    // History: only a write can clear a flag or move pin ownership
    // ------------------------------------------------------------
    logic take;
    logic [2:0] wr_r;
    logic rd_r;
    logic [7:0] p7_r;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            {wr_r, rd_r, p7_r} <= 12'h000;
        else
            {wr_r, rd_r, p7_r} <= {wr_r[1:0], take && hwrite, take && !hwrite, p7_r[6:0], chan_pin_i[3]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_drop(logic x);
        $fell(x) |-> |wr_r;
    endproperty
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    AST_RD_IDLE: assert property (!rd_r |-> hrdata == 32'h0000_0000)
        else $error("read data outside read");
    AST_CHAN_DROP: assert property (|($past(irq_chan) & ~irq_chan) |-> |wr_r)
        else $error("channel irq fell unwritten");
    AST_AIN_DROP: assert property (p_drop(irq_accum_input))
        else $error("input irq fell unwritten");
    AST_AOVF_DROP: assert property (p_drop(irq_accum_overflow))
        else $error("overflow irq fell unwritten");
    AST_TOF_DROP: assert property (p_drop(irq_counter_overflow))
        else $error("counter irq fell unwritten");
    AST_OE_OWNER: assert property ($changed(chan_pin_oe) |-> |wr_r)
        else $error("pin enable moved unwritten");
    AST_AIN_RISE: assert property ($rose(irq_accum_input)
        |-> |wr_r || (p7_r != 8'h00 && p7_r != 8'hFF))
        else $error("input irq rose without pin edge");
endmodule : tpa_timer_monitor
bind tpa_timer_core tpa_timer_monitor chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .chan_pin_i(chan_pin_i), .chan_pin_oe(chan_pin_oe), .irq_chan(irq_chan),
    .irq_accum_input(irq_accum_input), .irq_accum_overflow(irq_accum_overflow),
    .irq_counter_overflow(irq_counter_overflow));
`default_nettype wire

// ===== verilog/tpa_pkg.sv
// Shared constants and state layout of the timer capture/compare and pulse accumulator block
package tpa_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 4;
    localparam int CNT_W = 16;
    localparam int PRE_W = 7;
    localparam int CH7_IDX = 3;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_OUTCTL = 8'h08;
    localparam logic [7:0] OFS_IRQEN = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_FORCE = 8'h14;
    localparam logic [7:0] OFS_CH7 = 8'h18;
    localparam logic [7:0] OFS_COUNT = 8'h1C;
    localparam logic [7:0] OFS_VAL0 = 8'h20;
    localparam logic [7:0] OFS_ACTL = 8'h30;
    localparam logic [7:0] OFS_AFLG = 8'h34;
    localparam logic [7:0] OFS_ACNT = 8'h38;
    localparam logic [7:0] OFS_PORT = 8'h3C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_PSEL_LSB = 0;
    localparam int CTRL_COUNTER_RESET_ON_CH7_BIT = 4;
    localparam int CTRL_OVIE_BIT = 5;
    localparam int CTRL_EN_BIT = 7;
    localparam int NIB_LO = 0;
    localparam int NIB_HI = 4;
    localparam int FLAGS_OVF_BIT = 4;
    localparam int ACTL_INIE_BIT = 0;
    localparam int ACTL_OVIE_BIT = 1;
    localparam int ACTL_EDGE_BIT = 4;
    localparam int ACTL_MODE_BIT = 5;
    localparam int ACTL_EN_BIT = 6;
    localparam int AFLG_IN_BIT = 0;
    localparam int AFLG_OVF_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam int GATE_DIV = 64;
    localparam logic [PRE_W-1:0] GATE_MASK = PRE_W'(GATE_DIV - 1);

    // ------------------------------------------------------------------
    // Whole state of the core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic timer_enable_bit;
        logic [2:0] prescale_select;
        logic counter_reset_on_ch7;
        logic cnt_ovf_irq_enable;
        logic counter_overflow_flag;
        logic [PRE_W-1:0] prescale;
        logic [CNT_W-1:0] count;
        logic [NUM_CHAN-1:0] chan_dir_select;
        logic [NUM_CHAN-1:0] out_mode_bit;
        logic [NUM_CHAN-1:0] out_level_bit;
        logic [NUM_CHAN-1:0] chan_irq_enable;
        logic [NUM_CHAN-1:0] chan_event_flag;
        logic [NUM_CHAN-1:0] ch7_compare_mask;
        logic [NUM_CHAN-1:0] ch7_compare_data;
        logic [NUM_CHAN-1:0] port_latch;
        logic [NUM_CHAN-1:0] port_dir;
        logic [NUM_CHAN-1:0] cmp_level;
        logic [NUM_CHAN-1:0] pin_prev;
        logic [NUM_CHAN-1:0] pin_o;
        logic [NUM_CHAN-1:0] pin_oe;
        logic [NUM_CHAN-1:0][CNT_W-1:0] chan_capture_compare_value;
        logic accum_enable;
        logic accum_mode_select;
        logic accum_edge_select;
        logic accum_input_irq_enable;
        logic accum_overflow_irq_enable;
        logic accum_overflow_flag;
        logic accum_input_flag;
        logic [CNT_W-1:0] pulse_accum_count;
        logic [NUM_CHAN-1:0] irq_chan;
        logic irq_accum_input;
        logic irq_accum_overflow;
        logic irq_counter_overflow;
    } tpa_state_t;

endpackage : tpa_pkg

// ===== verilog/tpa_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module tpa_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_level
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [W-1:0] meta_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;

    // A level only counts once stages two and three agree, so a single
    // sample of a glitch never reaches the edge detectors
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end
        else
        begin
            meta_r <= pin_async;
            s2_r <= meta_r;
            s3_r <= s2_r;
            lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
        end
    end

    assign pin_level = lvl_r;

endmodule : tpa_sync

`default_nettype wire

// ===== verilog/tpa_timer_core.sv
// Timer capture/compare unit with pulse accumulator behind an AHB-Lite slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

module tpa_timer_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] chan_pin_i,
    output logic [3:0] chan_pin_o,
    output logic [3:0] chan_pin_oe,
    output logic [3:0] irq_chan,
    output logic irq_accum_input,
    output logic irq_accum_overflow,
    output logic irq_counter_overflow
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Compare pin action from the mode/level pair
    function automatic logic pin_act(input logic md, input logic lv, input logic cur);
        logic r;
        r = cur;
        case ({md, lv})
            2'b01: r = ~cur;
            2'b10: r = 1'b0;
            2'b11: r = 1'b1;
            default: r = cur;
        endcase
        return r;
    endfunction : pin_act

    // Register read view of a state image
    function automatic logic [31:0] rd_word(input tpa_pkg::tpa_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = tpa_pkg::RD_ZERO;
        case (a)
            tpa_pkg::OFS_CTRL:
            begin
                r[tpa_pkg::CTRL_PSEL_LSB +: 3] = s.prescale_select;
                r[tpa_pkg::CTRL_COUNTER_RESET_ON_CH7_BIT] = s.counter_reset_on_ch7;
                r[tpa_pkg::CTRL_OVIE_BIT] = s.cnt_ovf_irq_enable;
                r[tpa_pkg::CTRL_EN_BIT] = s.timer_enable_bit;
            end
            tpa_pkg::OFS_DIR: r[3:0] = s.chan_dir_select;
            tpa_pkg::OFS_OUTCTL:
            begin
                r[tpa_pkg::NIB_LO +: 4] = s.out_mode_bit;
                r[tpa_pkg::NIB_HI +: 4] = s.out_level_bit;
            end
            tpa_pkg::OFS_IRQEN: r[3:0] = s.chan_irq_enable;
            tpa_pkg::OFS_FLAGS:
            begin
                r[3:0] = s.chan_event_flag;
                r[tpa_pkg::FLAGS_OVF_BIT] = s.counter_overflow_flag;
            end
            tpa_pkg::OFS_CH7:
            begin
                r[tpa_pkg::NIB_LO +: 4] = s.ch7_compare_mask;
                r[tpa_pkg::NIB_HI +: 4] = s.ch7_compare_data;
            end
            tpa_pkg::OFS_COUNT: r[15:0] = s.count;
            tpa_pkg::OFS_ACTL:
            begin
                r[tpa_pkg::ACTL_INIE_BIT] = s.accum_input_irq_enable;
                r[tpa_pkg::ACTL_OVIE_BIT] = s.accum_overflow_irq_enable;
                r[tpa_pkg::ACTL_EDGE_BIT] = s.accum_edge_select;
                r[tpa_pkg::ACTL_MODE_BIT] = s.accum_mode_select;
                r[tpa_pkg::ACTL_EN_BIT] = s.accum_enable;
            end
            tpa_pkg::OFS_AFLG:
            begin
                r[tpa_pkg::AFLG_IN_BIT] = s.accum_input_flag;
                r[tpa_pkg::AFLG_OVF_BIT] = s.accum_overflow_flag;
            end
            tpa_pkg::OFS_ACNT: r[15:0] = s.pulse_accum_count;
            tpa_pkg::OFS_PORT:
            begin
                r[tpa_pkg::NIB_LO +: 4] = s.port_latch;
                r[tpa_pkg::NIB_HI +: 4] = s.port_dir;
            end
            default:
            begin
                // Channel value words; everything else reads zero
                if (a[7:4] == tpa_pkg::OFS_VAL0[7:4] && a[1:0] == 2'b00)
                begin
                    r[15:0] = s.chan_capture_compare_value[a[3:2]];
                end
            end
        endcase
        return r;
    endfunction : rd_word

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [3:0] pin_lvl;

    tpa_sync #(
        .W(tpa_pkg::NUM_CHAN)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_async(chan_pin_i),
        .pin_level(pin_lvl)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    tpa_pkg::tpa_state_t st_r;
    tpa_pkg::tpa_state_t st_nxt;

    logic [3:0] force_v;
    logic [3:0] flg_clr;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] match;
    logic [3:0] own;
    logic [tpa_pkg::PRE_W-1:0] pmask;
    logic tick;
    logic div64;
    logic ovf_clr;
    logic aovf_clr;
    logic ain_clr;
    logic acnt_wr;
    logic inc;
    logic act_prev;
    logic act_now;
    logic [7:0] wa;

    // One process computes the whole next image; bus writes apply their
    // clears first so that a hardware set in the same cycle still wins
    always_comb
    begin
        st_nxt = st_r;
        force_v = '0;
        flg_clr = '0;
        ovf_clr = 1'b0;
        aovf_clr = 1'b0;
        ain_clr = 1'b0;
        acnt_wr = 1'b0;
        inc = 1'b0;
        wa = st_r.wr_addr;

        // Address phase: remember writes for the data phase
        st_nxt.hreadyout = 1'b1;
        st_nxt.hresp = 1'b0;
        st_nxt.wr_pend = hsel & hready & htrans[1] & hwrite;
        if (hsel && hready && htrans[1])
        begin
            st_nxt.wr_addr = haddr[7:0];
        end

        // Data phase of a write
        if (st_r.wr_pend)
        begin
            case (wa)
                tpa_pkg::OFS_CTRL:
                begin
                    st_nxt.prescale_select = hwdata[tpa_pkg::CTRL_PSEL_LSB +: 3];
                    st_nxt.counter_reset_on_ch7 = hwdata[tpa_pkg::CTRL_COUNTER_RESET_ON_CH7_BIT];
                    st_nxt.cnt_ovf_irq_enable = hwdata[tpa_pkg::CTRL_OVIE_BIT];
                    st_nxt.timer_enable_bit = hwdata[tpa_pkg::CTRL_EN_BIT];
                end
                tpa_pkg::OFS_DIR: st_nxt.chan_dir_select = hwdata[3:0];
                tpa_pkg::OFS_OUTCTL:
                begin
                    st_nxt.out_mode_bit = hwdata[tpa_pkg::NIB_LO +: 4];
                    st_nxt.out_level_bit = hwdata[tpa_pkg::NIB_HI +: 4];
                end
                tpa_pkg::OFS_IRQEN: st_nxt.chan_irq_enable = hwdata[3:0];
                tpa_pkg::OFS_FLAGS:
                begin
                    flg_clr = hwdata[3:0];
                    ovf_clr = hwdata[tpa_pkg::FLAGS_OVF_BIT];
                end
                tpa_pkg::OFS_FORCE: force_v = hwdata[3:0];
                tpa_pkg::OFS_CH7:
                begin
                    st_nxt.ch7_compare_mask = hwdata[tpa_pkg::NIB_LO +: 4];
                    st_nxt.ch7_compare_data = hwdata[tpa_pkg::NIB_HI +: 4];
                end
                tpa_pkg::OFS_ACTL:
                begin
                    st_nxt.accum_input_irq_enable = hwdata[tpa_pkg::ACTL_INIE_BIT];
                    st_nxt.accum_overflow_irq_enable = hwdata[tpa_pkg::ACTL_OVIE_BIT];
                    st_nxt.accum_edge_select = hwdata[tpa_pkg::ACTL_EDGE_BIT];
                    st_nxt.accum_mode_select = hwdata[tpa_pkg::ACTL_MODE_BIT];
                    st_nxt.accum_enable = hwdata[tpa_pkg::ACTL_EN_BIT];
                end
                tpa_pkg::OFS_AFLG:
                begin
                    aovf_clr = hwdata[tpa_pkg::AFLG_OVF_BIT];
                    ain_clr = hwdata[tpa_pkg::AFLG_IN_BIT];
                end
                tpa_pkg::OFS_ACNT: acnt_wr = 1'b1;
                tpa_pkg::OFS_PORT:
                begin
                    st_nxt.port_latch = hwdata[tpa_pkg::NIB_LO +: 4];
                    st_nxt.port_dir = hwdata[tpa_pkg::NIB_HI +: 4];
                end
                default:
                begin
                    if (wa[7:4] == tpa_pkg::OFS_VAL0[7:4] && wa[1:0] == 2'b00)
                    begin
                        st_nxt.chan_capture_compare_value[wa[3:2]] = hwdata[15:0];
                    end
                end
            endcase
        end
        st_nxt.chan_event_flag = st_r.chan_event_flag & ~flg_clr;
        st_nxt.counter_overflow_flag = st_r.counter_overflow_flag & ~ovf_clr;
        st_nxt.accum_overflow_flag = st_r.accum_overflow_flag & ~aovf_clr;
        st_nxt.accum_input_flag = st_r.accum_input_flag & ~ain_clr;

        // Prescaler runs only while the timer is enabled, so the gate
        // clock for the accumulator vanishes with it
        pmask = tpa_pkg::PRE_W'((8'h01 << st_r.prescale_select) - 8'h01);
        tick = st_r.timer_enable_bit && ((st_r.prescale & pmask) == pmask);
        div64 = st_r.timer_enable_bit
            && ((st_r.prescale & tpa_pkg::GATE_MASK) == tpa_pkg::GATE_MASK);
        st_nxt.prescale = st_r.timer_enable_bit ? st_r.prescale + 1'b1 : '0;

        // Pin edges from the filtered levels
        st_nxt.pin_prev = pin_lvl;
        rise = pin_lvl & ~st_r.pin_prev;
        fall = ~pin_lvl & st_r.pin_prev;

        // Compare matches are taken once per counter value
        for (int i = 0; i < tpa_pkg::NUM_CHAN; i++)
        begin
            match[i] = st_r.chan_dir_select[i] && tick
                && (st_r.count == st_r.chan_capture_compare_value[i]);
        end

        // Free-running counter with optional reset on channel seven
        if (tick)
        begin
            if (match[tpa_pkg::CH7_IDX] && st_r.counter_reset_on_ch7)
            begin
                st_nxt.count = tpa_pkg::CNT_RST;
            end
            else
            begin
                st_nxt.count = st_r.count + 1'b1;
                if (st_r.count == tpa_pkg::CNT_MAX)
                begin
                    st_nxt.counter_overflow_flag = 1'b1;
                end
            end
        end

        // Per channel capture or compare
        for (int i = 0; i < tpa_pkg::NUM_CHAN; i++)
        begin
            if (!st_r.chan_dir_select[i] && rise[i])
            begin
                st_nxt.chan_capture_compare_value[i] = st_r.count;
                st_nxt.chan_event_flag[i] = 1'b1;
            end
            if (st_r.chan_dir_select[i] && (match[i] || force_v[i]))
            begin
                st_nxt.cmp_level[i] = pin_act(st_r.out_mode_bit[i],
                    st_r.out_level_bit[i], st_r.cmp_level[i]);
            end
            if (match[i])
            begin
                st_nxt.chan_event_flag[i] = 1'b1;
            end
        end

        // Channel seven overrides the other channels on masked pins
        if (st_r.chan_dir_select[tpa_pkg::CH7_IDX]
            && (match[tpa_pkg::CH7_IDX] || force_v[tpa_pkg::CH7_IDX]))
        begin
            for (int i = 0; i < tpa_pkg::NUM_CHAN; i++)
            begin
                if (st_r.ch7_compare_mask[i])
                begin
                    st_nxt.cmp_level[i] = st_r.ch7_compare_data[i];
                end
            end
        end

        // Pin ownership: compare logic, else the port latch
        for (int i = 0; i < tpa_pkg::NUM_CHAN; i++)
        begin
            own[i] = st_nxt.chan_dir_select[i]
                && (st_nxt.out_mode_bit[i] || st_nxt.out_level_bit[i]);
            own[i] = own[i] || (st_nxt.ch7_compare_mask[i]
                && st_nxt.chan_dir_select[tpa_pkg::CH7_IDX]);
        end
        st_nxt.pin_o = (own & st_nxt.cmp_level) | (~own & st_nxt.port_latch);
        st_nxt.pin_oe = own | st_nxt.port_dir;

        // Pulse accumulator on the channel seven pin
        act_prev = st_r.pin_prev[tpa_pkg::CH7_IDX] ^ st_r.accum_edge_select;
        act_now = pin_lvl[tpa_pkg::CH7_IDX] ^ st_r.accum_edge_select;
        if (st_r.accum_enable)
        begin
            if (!st_r.accum_mode_select)
            begin
                // Event counting needs no prescaler tick
                inc = st_r.accum_edge_select ? rise[tpa_pkg::CH7_IDX]
                    : fall[tpa_pkg::CH7_IDX];
                if (inc)
                begin
                    st_nxt.accum_input_flag = 1'b1;
                end
            end
            else
            begin
                inc = act_now && div64;
                if (act_prev && !act_now)
                begin
                    st_nxt.accum_input_flag = 1'b1;
                end
            end
        end
        if (inc)
        begin
            st_nxt.pulse_accum_count = st_r.pulse_accum_count + 1'b1;
            if (st_r.pulse_accum_count == tpa_pkg::CNT_MAX)
            begin
                st_nxt.accum_overflow_flag = 1'b1;
            end
        end
        // A software load beats a count in the same cycle
        if (acnt_wr)
        begin
            st_nxt.pulse_accum_count = hwdata[15:0];
        end

        // Request outputs register on the same edge as the flags
        st_nxt.irq_chan = st_nxt.chan_event_flag & st_nxt.chan_irq_enable;
        st_nxt.irq_accum_input = st_nxt.accum_input_flag
            & st_nxt.accum_input_irq_enable;
        st_nxt.irq_accum_overflow = st_nxt.accum_overflow_flag
            & st_nxt.accum_overflow_irq_enable;
        st_nxt.irq_counter_overflow = st_nxt.counter_overflow_flag
            & st_nxt.cnt_ovf_irq_enable;

        // Read data reflects a write in flight, so back-to-back access is safe
        st_nxt.hrdata = tpa_pkg::RD_ZERO;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            st_nxt.hrdata = rd_word(st_nxt, haddr[7:0]);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.hreadyout <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign hreadyout = st_r.hreadyout;
    assign hresp = st_r.hresp;
    assign hrdata = st_r.hrdata;
    assign chan_pin_o = st_r.pin_o;
    assign chan_pin_oe = st_r.pin_oe;
    assign irq_chan = st_r.irq_chan;
    assign irq_accum_input = st_r.irq_accum_input;
    assign irq_accum_overflow = st_r.irq_accum_overflow;
    assign irq_counter_overflow = st_r.irq_counter_overflow;

endmodule : tpa_timer_core

`default_nettype wire
